// *** link_model.sv ***
// Link controller model issuing single register requests
`timescale 1ns/1ps
`default_nettype none
module link_model (
    input wire logic ulpi_clk,
    input wire logic rsp_valid_r,
    input wire tail_pkg::reg_rsp_t rsp_r,
    output logic req_valid,
    output tail_pkg::reg_req_t req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    task automatic access(input tail_pkg::op_t op, input logic [5:0] ia, input logic [7:0] ea,
                          input logic [7:0] wd, output logic [7:0] rd, output logic hit);
        logic [7:0] w;
        logic [7:0] ex;
        logic [7:0] tgt;
        w = wd;
        ex = {2'b00, ea[5:0]};
        tgt = (ia == 6'h2f) ? ex : {2'b00, ia};
        if (tgt == 8'h3d || tgt == 8'h3e) begin
            w[7:4] = 4'h0;
        end
        @(posedge ulpi_clk);
        req_valid <= 1'b1;
        req <= '{op: op, imm_addr: ia, ext_addr: ex, wdata: w};
        @(posedge ulpi_clk);
        req_valid <= 1'b0;
        // Released request fields toggle so a stale value cannot pass for a live one
        req <= ~req;
        @(negedge ulpi_clk);
        rd = rsp_r.rdata;
        hit = (rsp_valid_r === 1'b1) ? rsp_r.hit : 1'bx;
    endtask
endmodule
`default_nettype wire

// *** pulse_cross.sv ***
// Toggle-based single-pulse crossing between two clocks
`timescale 1ns/1ps
`default_nettype none
module pulse_cross (
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_pulse,
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_pulse
);

    logic tog_r;
    logic tog_s;
    logic tog_d_r;

    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            tog_r <= 1'b0;
        end else begin
            tog_r <= tog_r ^ src_pulse;
        end
    end

    sync_bits #(.W(1)) u_sync (
        .clk(dst_clk),
        .rst(dst_rst),
        .d(tog_r),
        .q(tog_s)
    );

    // Two pulses closer than a few link cycles can cancel out; edge reports are sparse
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            tog_d_r <= 1'b0;
            dst_pulse <= 1'b0;
        end else begin
            tog_d_r <= tog_s;
            dst_pulse <= tog_s ^ tog_d_r;
        end
    end

endmodule
`default_nettype wire

// *** reg_map_tail.sv ***
// Upper register map: line monitor, test byte, power pin control
`timescale 1ns/1ps
`default_nettype none

module reg_map_tail (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ulpi_clk,
    input wire logic req_valid,
    input wire tail_pkg::reg_req_t req,
    output tail_pkg::reg_rsp_t rsp_r,
    output logic rsp_valid_r,
    input wire logic [1:0] line_state,
    input wire logic bvalid,
    input wire logic power_switch_on,
    input wire logic shared_pin_in,
    output logic shared_pin_out_r,
    output logic shared_pin_oe_n_r,
    output logic pin_reset_req_r,
    output logic rxcmd_valid_r,
    output logic [7:0] rxcmd_r
);

    function automatic tail_pkg::target_t target_of(input logic [7:0] a);
        if (a == tail_pkg::ADDR_LINE_MON) begin
            return tail_pkg::T_LINE;
        end else if (a >= tail_pkg::ADDR_TEST_W && a <= tail_pkg::ADDR_TEST_C) begin
            return tail_pkg::T_TEST;
        end else if (a >= tail_pkg::ADDR_PWR_W && a <= tail_pkg::ADDR_PWR_C) begin
            return tail_pkg::T_PWR;
        end else begin
            return tail_pkg::T_NONE;
        end
    endfunction

    function automatic tail_pkg::kind_t kind_of(input logic [7:0] a);
        if (a == tail_pkg::ADDR_TEST_S || a == tail_pkg::ADDR_PWR_S) begin
            return tail_pkg::K_SET;
        end else if (a == tail_pkg::ADDR_TEST_C || a == tail_pkg::ADDR_PWR_C) begin
            return tail_pkg::K_CLEAR;
        end else begin
            return tail_pkg::K_WRITE;
        end
    endfunction

    function automatic logic [7:0] apply(
        input logic [7:0] old,
        input logic [7:0] wd,
        input tail_pkg::kind_t k
    );
        case (k)
            tail_pkg::K_SET: return old | wd;
            tail_pkg::K_CLEAR: return old & ~wd;
            default: return wd;
        endcase
    endfunction

    // Link-domain reset, released on the link clock
    logic rst_l;
    sync_bits #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
        .clk(ulpi_clk),
        .rst(1'b0),
        .d(sys_rst),
        .q(rst_l)
    );

    logic [1:0] ls_s;
    sync_bits #(.W(2)) u_ls_sync (
        .clk(ulpi_clk),
        .rst(rst_l),
        .d(line_state),
        .q(ls_s)
    );

    // Reset pin idles high, so its synchroniser resets high
    logic pin_s;
    sync_bits #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
        .clk(ulpi_clk),
        .rst(rst_l),
        .d(shared_pin_in),
        .q(pin_s)
    );

    // ---------------- Register access, link domain ----------------
    logic [7:0] test_r;
    logic [7:0] pwr_r;
    logic [7:0] test_nxt;
    logic [7:0] pwr_nxt;

    wire escape = req.imm_addr == tail_pkg::ADDR_ESCAPE;
    wire [7:0] eff_addr = escape ? req.ext_addr : {2'b00, req.imm_addr};
    wire ext_bad = escape && (req.ext_addr >= tail_pkg::ADDR_EXT_LIMIT);
    wire tail_pkg::target_t tgt = ext_bad ? tail_pkg::T_NONE : target_of(eff_addr);
    wire tail_pkg::kind_t kind = kind_of(eff_addr);
    wire is_wr = req_valid && req.op == tail_pkg::OP_WRITE;
    wire is_rd = req_valid && req.op == tail_pkg::OP_READ;
    wire wr_test = is_wr && tgt == tail_pkg::T_TEST;
    wire wr_pwr = is_wr && tgt == tail_pkg::T_PWR;

    // Reserved bits 7:4 are stored as written; the link keeps them zero
    assign test_nxt = wr_test ? apply(test_r, req.wdata, kind) : test_r;
    assign pwr_nxt = wr_pwr ? apply(pwr_r, req.wdata, kind) : pwr_r;

    wire [7:0] line_word = {6'h00, ls_s};
    wire [7:0] rd_mux =
        (tgt == tail_pkg::T_LINE) ? line_word :
        (tgt == tail_pkg::T_TEST) ? test_r :
        (tgt == tail_pkg::T_PWR) ? pwr_r : 8'h00;
    wire tail_pkg::reg_rsp_t rsp_nxt = '{
        hit: tgt != tail_pkg::T_NONE,
        rdata: is_rd ? rd_mux : 8'h00
    };

    // The test byte is stored and read back only; no other logic reads it
    always_ff @(posedge ulpi_clk) begin
        if (rst_l) begin
            test_r <= tail_pkg::TEST_RST;
            pwr_r <= tail_pkg::PWR_RST;
        end else begin
            test_r <= test_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    always_ff @(posedge ulpi_clk) begin
        if (rst_l) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rsp_valid_r <= req_valid;
            rsp_r <= rsp_nxt;
        end
    end

    // ---------------- Shared pin function ----------------
    wire switch_mode = pwr_r[tail_pkg::PWR_PINSEL_BIT];

    always_ff @(posedge ulpi_clk) begin
        if (rst_l) begin
            shared_pin_oe_n_r <= 1'b1;
            shared_pin_out_r <= 1'b1;
            pin_reset_req_r <= 1'b0;
        end else begin
            shared_pin_oe_n_r <= ~switch_mode;
            shared_pin_out_r <= ~power_switch_on;
            pin_reset_req_r <= ~switch_mode & ~pin_s;
        end
    end

    // ---------------- Session valid edges, system domain ----------------
    logic bv_s;
    logic bv_d_r;
    logic [1:0] en_s;
    logic evt;
    logic evt_l;

    sync_bits #(.W(1)) u_bv_sync (
        .clk(clk),
        .rst(sys_rst),
        .d(bvalid),
        .q(bv_s)
    );

    // Enables arrive a few cycles late; edges right after a write may be missed
    sync_bits #(.W(2)) u_en_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({pwr_r[tail_pkg::PWR_FALL_BIT], pwr_r[tail_pkg::PWR_RISE_BIT]}),
        .q(en_s)
    );

    wire bv_rise = bv_s & ~bv_d_r;
    wire bv_fall = ~bv_s & bv_d_r;
    wire evt_nxt = (bv_rise & en_s[0]) | (bv_fall & en_s[1]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bv_d_r <= 1'b0;
            evt <= 1'b0;
        end else begin
            bv_d_r <= bv_s;
            evt <= evt_nxt;
        end
    end

    pulse_cross u_evt_cross (
        .src_clk(clk),
        .src_rst(sys_rst),
        .src_pulse(evt),
        .dst_clk(ulpi_clk),
        .dst_rst(rst_l),
        .dst_pulse(evt_l)
    );

    // ---------------- Receive command, link domain ----------------
    logic [7:0] rxcmd_nxt;
    always_comb begin
        rxcmd_nxt = line_word;
        rxcmd_nxt[tail_pkg::RXCMD_ALT_BIT] = 1'b1;
    end

    always_ff @(posedge ulpi_clk) begin
        if (rst_l) begin
            rxcmd_valid_r <= 1'b0;
            rxcmd_r <= 8'h00;
        end else begin
            rxcmd_valid_r <= evt_l;
            rxcmd_r <= evt_l ? rxcmd_nxt : rxcmd_r;
        end
    end

    // ---------------- Checks ----------------
    a_line_read: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        is_rd && tgt == tail_pkg::T_LINE
        |=> rsp_valid_r && rsp_r.hit && rsp_r.rdata == {6'h00, $past(ls_s)}
    ) else $error("line monitor read data wrong");

    a_test_write: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_test && eff_addr == tail_pkg::ADDR_TEST_W
        |=> test_r == $past(req.wdata) ##1 test_r == $past(test_r)
            || $past(req_valid)
    ) else $error("test byte write lost");

    a_test_set: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_test && eff_addr == tail_pkg::ADDR_TEST_S
        |=> test_r == ($past(test_r) | $past(req.wdata))
    ) else $error("test byte set wrong");

    a_test_clear: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_test && eff_addr == tail_pkg::ADDR_TEST_C
        |=> test_r == ($past(test_r) & ~$past(req.wdata))
    ) else $error("test byte clear wrong");

    a_pwr_clear: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_pwr && eff_addr == tail_pkg::ADDR_PWR_C
        |=> pwr_r == ($past(pwr_r) & ~$past(req.wdata))
    ) else $error("power control clear wrong");

    a_pwr_set: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_pwr && eff_addr == tail_pkg::ADDR_PWR_S
        |=> pwr_r == ($past(pwr_r) | $past(req.wdata))
    ) else $error("power control set wrong");

    a_pwr_write: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        wr_pwr && eff_addr == tail_pkg::ADDR_PWR_W
        |=> pwr_r == $past(req.wdata)
    ) else $error("power control write lost");

    a_quiet_unimp: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        req_valid && eff_addr >= tail_pkg::ADDR_UNIMP_LO
            && eff_addr <= tail_pkg::ADDR_UNIMP_HI
        |=> $stable(test_r) && $stable(pwr_r) && !rsp_r.hit
            && rsp_r.rdata == 8'h00
    ) else $error("unimplemented access had an effect");

    a_ext_alias: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        is_wr && escape && req.ext_addr == tail_pkg::ADDR_PWR_W
        |=> pwr_r == $past(req.wdata)
    ) else $error("extended alias did not reach register");

    a_escape_nodata: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        req_valid && escape && req.ext_addr >= tail_pkg::ADDR_VEND_LO
            && req.ext_addr < tail_pkg::ADDR_PWR_W
        |=> !rsp_r.hit && $stable(pwr_r) && $stable(test_r)
    ) else $error("escape window produced data");

    a_reset_vals: assert property (
        @(posedge ulpi_clk)
        $past(rst_l) && !rst_l |-> pwr_r == 8'h00 && test_r == 8'h00
    ) else $error("registers not zero after reset");

    a_alt_rxcmd: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        evt_l |=> rxcmd_valid_r && rxcmd_r[tail_pkg::RXCMD_ALT_BIT]
            && rxcmd_r[1:0] == $past(ls_s) ##1 !rxcmd_valid_r
    ) else $error("receive command missing or malformed");

    a_edge_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(bv_s) && en_s[1] |=> evt
    ) else $error("enabled falling edge not reported");

    a_pin_mode: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        !switch_mode ##1 !switch_mode |-> shared_pin_oe_n_r
            && pin_reset_req_r == !$past(pin_s)
    ) else $error("shared pin not in reset-input mode");

    a_vendor_empty: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        req_valid && eff_addr >= tail_pkg::ADDR_VEND_LO
            && eff_addr < tail_pkg::ADDR_PWR_W
        |=> !rsp_r.hit && rsp_r.rdata == 8'h00
            && $stable(pwr_r) && $stable(test_r)
    ) else $error("empty vendor address had an effect");

    a_escape_empty: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        req_valid && escape && req.ext_addr == {2'b00, tail_pkg::ADDR_ESCAPE}
        |=> !rsp_r.hit && rsp_r.rdata == 8'h00 && $stable(pwr_r) && $stable(test_r)
    ) else $error("escape address held data");

    a_rise_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(bv_s) && en_s[0] |=> evt
    ) else $error("enabled rising edge not reported");

    a_edge_off: assert property (
        @(posedge clk) disable iff (sys_rst)
        !en_s[0] && !en_s[1] |=> !evt
    ) else $error("edge reported while both enables off");

    a_switch_mode: assert property (
        @(posedge ulpi_clk) disable iff (rst_l)
        switch_mode ##1 switch_mode |-> !shared_pin_oe_n_r && !pin_reset_req_r
            && shared_pin_out_r == !$past(power_switch_on)
    ) else $error("shared pin not in power switch mode");

endmodule
`default_nettype wire

// *** reg_map_tail_tb.sv ***
// Self-checking testbench for the upper register map block
`timescale 1ns/1ps
`default_nettype none
module reg_map_tail_tb;
    logic clk, ulpi_clk, sys_rst, req_valid, bvalid, power_switch_on, shared_pin_in;
    logic rsp_valid_r, shared_pin_out_r, shared_pin_oe_n_r, pin_reset_req_r, rxcmd_valid_r;
    logic [1:0] line_state;
    logic [7:0] rxcmd_r;
    logic [7:0] rd;
    logic hit;
    tail_pkg::reg_req_t req;
    tail_pkg::reg_rsp_t rsp_r;
    int fail_count = 0;
    int n_checks = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Link clock offset so the two domains never share edges
    initial begin
        ulpi_clk = 1'b0;
        #7;
        forever #15 ulpi_clk = ~ulpi_clk;
    end

    reg_map_tail reg_map_tail_inst (
        .clk(clk), .sys_rst(sys_rst), .ulpi_clk(ulpi_clk), .req_valid(req_valid), .req(req),
        .rsp_r(rsp_r), .rsp_valid_r(rsp_valid_r), .line_state(line_state), .bvalid(bvalid),
        .power_switch_on(power_switch_on), .shared_pin_in(shared_pin_in),
        .shared_pin_out_r(shared_pin_out_r), .shared_pin_oe_n_r(shared_pin_oe_n_r),
        .pin_reset_req_r(pin_reset_req_r), .rxcmd_valid_r(rxcmd_valid_r), .rxcmd_r(rxcmd_r)
    );
    link_model link_model_inst (
        .ulpi_clk(ulpi_clk), .rsp_valid_r(rsp_valid_r), .rsp_r(rsp_r), .req_valid(req_valid), .req(req)
    );

    task automatic stop_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] ia, input logic [7:0] ea, input logic [7:0] wd);
        link_model_inst.access(tail_pkg::OP_WRITE, ia, ea, wd, rd, hit);
    endtask
    task automatic rdc(input string name, input logic [5:0] ia, input logic [7:0] ea,
                       input logic [7:0] exp, input logic eh);
        link_model_inst.access(tail_pkg::OP_READ, ia, ea, 8'h00, rd, hit);
        chk(name, exp, rd);
        chk({name, "_hit"}, {7'h00, eh}, {7'h00, hit});
    endtask
    task automatic ucyc(input int n);
        repeat (n) @(posedge ulpi_clk);
    endtask

    task automatic t_reset;
        rdc("test_rst", 6'h16, 8'h00, 8'h00, 1'b1);
        rdc("pwr_rst", 6'h3d, 8'h00, 8'h00, 1'b1);
        chk("oe_n_rst", 8'h01, {7'h00, shared_pin_oe_n_r});
        @(posedge ulpi_clk) line_state <= 2'b10;
        ucyc(4);
        rdc("line_mon", 6'h15, 8'h00, 8'h02, 1'b1);
        @(posedge ulpi_clk) line_state <= 2'b01;
        ucyc(4);
        rdc("line_mon", 6'h15, 8'h00, 8'h01, 1'b1);
    endtask
    task automatic t_test_byte;
        wr(6'h16, 8'h00, 8'ha5);
        wr(6'h17, 8'h00, 8'h5a);
        rdc("test_set", 6'h16, 8'h00, 8'hff, 1'b1);
        wr(6'h18, 8'h00, 8'h0f);
        rdc("test_clr", 6'h16, 8'h00, 8'hf0, 1'b1);
        rdc("test_r17", 6'h17, 8'h00, 8'hf0, 1'b1);
        rdc("test_r18", 6'h18, 8'h00, 8'hf0, 1'b1);
        chk("oe_n_test", 8'h01, {7'h00, shared_pin_oe_n_r});
        chk("rxcmd_test", 8'h00, {7'h00, rxcmd_valid_r});
    endtask
    task automatic t_unimp;
        logic [5:0] addrs [4] = '{6'h19, 6'h2e, 6'h30, 6'h3c};
        foreach (addrs[i]) begin
            wr(addrs[i], 8'h00, 8'hff);
            rdc("unimp", addrs[i], 8'h00, 8'h00, 1'b0);
        end
        wr(6'h2f, 8'h30, 8'hff);
        rdc("ext_vend", 6'h2f, 8'h3c, 8'h00, 1'b0);
        rdc("test_keep", 6'h16, 8'h00, 8'hf0, 1'b1);
        rdc("pwr_keep", 6'h3d, 8'h00, 8'h00, 1'b1);
    endtask
    task automatic t_ext;
        wr(6'h2f, 8'h16, 8'h3c);
        rdc("ext_test", 6'h16, 8'h00, 8'h3c, 1'b1);
        wr(6'h2f, 8'h3e, 8'h01);
        rdc("ext_pwr", 6'h3d, 8'h00, 8'h01, 1'b1);
        rdc("ext_rd", 6'h2f, 8'h3d, 8'h01, 1'b1);
        rdc("escape", 6'h2f, 8'h2f, 8'h00, 1'b0);
        wr(6'h2f, 8'h3f, 8'h01);
        rdc("ext_clr", 6'h3d, 8'h00, 8'h00, 1'b1);
        wr(6'h2f, 8'h3d, 8'h02);
        rdc("ext_wr", 6'h3d, 8'h00, 8'h02, 1'b1);
    endtask
    task automatic t_pin;
        @(posedge ulpi_clk) power_switch_on <= 1'b1;
        wr(6'h3d, 8'h00, 8'h01);
        ucyc(3);
        chk("oe_n_sw", 8'h00, {7'h00, shared_pin_oe_n_r});
        chk("pin_out_on", 8'h00, {7'h00, shared_pin_out_r});
        power_switch_on <= 1'b0;
        ucyc(3);
        chk("pin_out_off", 8'h01, {7'h00, shared_pin_out_r});
        shared_pin_in <= 1'b0;
        ucyc(4);
        chk("reset_req_sw", 8'h00, {7'h00, pin_reset_req_r});
        shared_pin_in <= 1'b1;
        wr(6'h3f, 8'h00, 8'h01);
        ucyc(3);
        chk("oe_n_rst_mode", 8'h01, {7'h00, shared_pin_oe_n_r});
        shared_pin_in <= 1'b0;
        ucyc(4);
        chk("reset_req", 8'h01, {7'h00, pin_reset_req_r});
        shared_pin_in <= 1'b1;
        ucyc(4);
        chk("reset_rel", 8'h00, {7'h00, pin_reset_req_r});
    endtask
    task automatic edge_rx(input logic lvl, input logic [7:0] exp_n);
        int n;
        n = 0;
        @(posedge clk) bvalid <= lvl;
        repeat (20) begin
            @(negedge ulpi_clk);
            if (rxcmd_valid_r === 1'b1) begin
                n++;
                chk("rxcmd", 8'h81, rxcmd_r);
            end
        end
        chk("rxcmd_count", exp_n, n[7:0]);
    endtask
    // Edge reports serve debug only; session tracking would use the comparator events
    task automatic t_edges;
        wr(6'h3e, 8'h00, 8'h0c);
        rdc("pwr_set", 6'h3e, 8'h00, 8'h0c, 1'b1);
        ucyc(4);
        edge_rx(1'b1, 8'h01);
        edge_rx(1'b0, 8'h01);
        wr(6'h3f, 8'h00, 8'h08);
        ucyc(4);
        edge_rx(1'b1, 8'h01);
        edge_rx(1'b0, 8'h00);
        wr(6'h3f, 8'h00, 8'h04);
        ucyc(4);
        edge_rx(1'b1, 8'h00);
    endtask
    // A reset in mid-run must bring the registers and the pin back to defaults
    task automatic t_mid_reset;
        wr(6'h16, 8'h00, 8'h77);
        wr(6'h3e, 8'h00, 8'h01);
        ucyc(3);
        chk("oe_n_pre_rst", 8'h00, {7'h00, shared_pin_oe_n_r});
        @(posedge clk) sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        ucyc(6);
        rdc("test_rerst", 6'h16, 8'h00, 8'h00, 1'b1);
        rdc("pwr_rerst", 6'h3d, 8'h00, 8'h00, 1'b1);
        chk("oe_n_rerst", 8'h01, {7'h00, shared_pin_oe_n_r});
    endtask

    initial begin
        #100000;
        fail_count++;
        stop_test;
    end
    initial begin
        sys_rst = 1'b1;
        bvalid = 1'b0;
        power_switch_on = 1'b0;
        shared_pin_in = 1'b1;
        line_state = 2'b00;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        ucyc(6);
        t_reset;
        t_test_byte;
        t_unimp;
        t_ext;
        t_pin;
        t_edges;
        t_mid_reset;
        stop_test;
    end
endmodule
`default_nettype wire

// *** sync_bits.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule
`default_nettype wire

// *** tail_pkg.sv ***
// Shared constants and types for the upper register map block
package tail_pkg;

    localparam logic [7:0] ADDR_LINE_MON = 8'h15;
    localparam logic [7:0] ADDR_TEST_W = 8'h16;
    localparam logic [7:0] ADDR_TEST_S = 8'h17;
    localparam logic [7:0] ADDR_TEST_C = 8'h18;
    localparam logic [7:0] ADDR_UNIMP_LO = 8'h19;
    localparam logic [7:0] ADDR_UNIMP_HI = 8'h2e;
    localparam logic [5:0] ADDR_ESCAPE = 6'h2f;
    localparam logic [7:0] ADDR_VEND_LO = 8'h30;
    localparam logic [7:0] ADDR_PWR_W = 8'h3d;
    localparam logic [7:0] ADDR_PWR_S = 8'h3e;
    localparam logic [7:0] ADDR_PWR_C = 8'h3f;
    localparam logic [7:0] ADDR_EXT_LIMIT = 8'h40;

    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [7:0] PWR_RST = 8'h00;

    localparam int PWR_FALL_BIT = 3;
    localparam int PWR_RISE_BIT = 2;
    localparam int PWR_PINSEL_BIT = 0;
    localparam int RXCMD_ALT_BIT = 7;

    typedef enum logic {OP_READ, OP_WRITE} op_t;
    typedef enum logic [1:0] {K_WRITE, K_SET, K_CLEAR} kind_t;
    typedef enum logic [1:0] {T_NONE, T_LINE, T_TEST, T_PWR} target_t;

    typedef struct packed {
        op_t op;
        logic [5:0] imm_addr;
        logic [7:0] ext_addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic hit;
        logic [7:0] rdata;
    } reg_rsp_t;

endpackage
